/* inc/ssc_pkg.sv */
// Purpose: shared constants for the slow channel message scheduler
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   ids, code tables and register layout live here only once
package ssc_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CFG1  = 12'h000;   // sent_config_word_one
   localparam logic [11:0] OFS_CFG2  = 12'h004;   // sent_config_word_two
   localparam logic [11:0] OFS_CONTROL_WORD_ONE = 12'h008;   // control_word_one
   localparam logic [11:0] OFS_STAT  = 12'h00c;   // scheduler position, read only
   localparam logic [11:0] OFS_OEM0  = 12'h010;   // first of eight user code words
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int CFG1_ESE_BIT   = 0;             // enhanced_serial_enable
   localparam int CFG1_REV_LSB   = 1;             // revision select, 2 bits
   localparam int CFG1_SID_BIT   = 3;             // sensor id select
   localparam int CFG1_TYPE_LSB  = 4;             // sensor type setting, 4 bits
   localparam int CFG2_PWMASK_BIT = 0;            // force pre-warning bit low
   localparam int CFG2_PWEN_BIT  = 1;             // pre-warning indication enable
   localparam int CONTROL_WORD_ONE_DIAG_BIT = 14;            // diagnostic-mode flag
   localparam logic [7:0]  CFG1_RST  = 8'h00;
   localparam logic [1:0]  CFG2_RST  = 2'h0;
   localparam logic        CONTROL_WORD_ONE_RST = 1'b0;
   localparam logic [11:0] OEM_RST   = 12'h000;
   // ------------------------------------------------------------
   // schedule and message ids
   // ------------------------------------------------------------
   localparam int N_FRAMES = 18;                  // frames per message
   localparam int N_MSG    = 18;                  // messages per cycle
   localparam int N_OEM    = 8;
   localparam logic [7:0] ID_DIAG = 8'h01;
   localparam logic [7:0] ID_TEMP = 8'h23;
   localparam logic [7:0] ID_VSUP = 8'h1c;
   localparam logic [7:0] ID_TYPE = 8'h03;
   localparam logic [7:0] ID_SID  = 8'h29;
   localparam logic [7:0] ID_MFR  = 8'h05;
   localparam logic [7:0] ID_REV  = 8'h06;
   localparam logic [3:0] ID_OEM_HI = 4'h9;       // 90h..97h
   localparam logic [7:0] MSG_ID [N_MSG] = '{ID_DIAG, ID_TEMP, ID_VSUP, ID_TYPE, ID_SID, ID_MFR, ID_REV,
      ID_DIAG, ID_TEMP, ID_VSUP, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
   // ------------------------------------------------------------
   // data codes
   // ------------------------------------------------------------
   localparam logic [11:0] DIAG_OK     = 12'h000;
   localparam logic [11:0] DIAG_OOR_HI = 12'h001;
   localparam logic [11:0] DIAG_OOR_LO = 12'h002;
   localparam logic [11:0] DIAG_UNDERV = 12'h020;
   localparam logic [11:0] DIAG_OVERV  = 12'h021;
   localparam logic [11:0] DIAG_TEMP   = 12'h022;
   localparam logic [11:0] DIAG_SBE    = 12'h023;
   localparam logic [11:0] DIAG_RSV_LO = 12'h024;  // first reserved code below safety codes
   localparam logic [11:0] DIAG_SAFE_MIN = 12'h801;
   localparam logic [11:0] TYPE_CODE [16] = '{12'h051, 12'h052, 12'h053, 12'h054, 12'h055, 12'h056,
      12'h059, 12'h05a, 12'h062, 12'h063, 12'h064, 12'h066, 12'h000, 12'h000, 12'h000, 12'h000};
   localparam logic [11:0] REV_CODE [4] = '{12'h000, 12'h002, 12'h003, 12'h004};
   localparam logic [11:0] SID_CODE0 = 12'h000;
   localparam logic [11:0] SID_CODE1 = 12'hfff;
   localparam logic [11:0] TEMP_MAX  = 12'h0ff;
   localparam logic [11:0] VSUP_MAX  = 12'h1ff;
   // ------------------------------------------------------------
   // serial frame layout and crc
   // ------------------------------------------------------------
   localparam logic [6:0] START_PAT = 7'b1111110;  // bit 3, frames 1..7
   localparam logic       CFG_BIT   = 1'b1;        // 12-bit data, 8-bit id
   localparam logic [5:0] CRC_SEED  = 6'h15;
   localparam logic [5:0] CRC_POLY  = 6'h19;       // x^6+x^4+x^3+1
endpackage

/* logic/ssc_crc6.sv */
// Purpose: six-bit crc over the 24 payload bits of one slow message
// Assumes: bits arrive msb first, one combinational pass
// Notes:   direct feed form, same result as the zero-augmented division
`timescale 1ns/100ps
`default_nettype none
module ssc_crc6
   import ssc_pkg::*;
(
   input  wire logic [23:0] crc_data,   // payload, first bit in msb
   output logic      [5:0]  crc_out     // remainder sent in frames 1..6
);
   // ------------------------------------------------------------
   // bitwise division
   // ------------------------------------------------------------
   always_comb begin
      logic [5:0] acc;
      logic       fb;
      acc = CRC_SEED;
      fb  = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         fb  = acc[5] ^ crc_data[i];
         acc = {acc[4:0], 1'b0};
         if (fb) begin
            acc = acc ^ CRC_POLY;
         end
      end
      crc_out = acc;
   end
endmodule
`default_nettype wire

/* logic/ssc_diag_enc.sv */
// Purpose: builds diagnostic status, safety error and sensor type codes
// Assumes: condition inputs are levels from the sensor core
// Notes:   pure combinational; the scheduler samples the codes per slot, any_warn per frame
`timescale 1ns/100ps
`default_nettype none
module ssc_diag_enc
   import ssc_pkg::*;
(
   input  wire logic        upper_range_limit,  // output above upper limit
   input  wire logic        lower_range_limit,  // output below lower limit
   input  wire logic        supply_under,       // supply below threshold
   input  wire logic        supply_over,        // supply above threshold
   input  wire logic        temp_high,          // chip temperature too high
   input  wire logic        mem_sbe,            // corrected single-bit error
   input  wire logic        diag_mode,          // control_word_one flag
   input  wire logic [10:0] check_fail,         // failed safety checks
   input  wire logic [3:0]  sensor_type,        // type setting
   output logic      [11:0] diag_code,          // diagnostic status data
   output logic      [11:0] type_code,          // sensor type data
   output logic             any_warn            // any pre-warning condition
);
   // ------------------------------------------------------------
   // code selection
   // ------------------------------------------------------------
   wire logic        safety_hit = diag_mode & (|check_fail);
   wire logic [11:0] safety_code = {diag_mode, check_fail};

   assign any_warn = upper_range_limit | lower_range_limit | supply_under |
                     supply_over | temp_high | mem_sbe;
   assign type_code = TYPE_CODE[sensor_type];

   // safety error wins; warnings in code order after it
   always_comb begin
      if (safety_hit) begin
         diag_code = safety_code;
      end else if (upper_range_limit) begin
         diag_code = DIAG_OOR_HI;
      end else if (lower_range_limit) begin
         diag_code = DIAG_OOR_LO;
      end else if (supply_under) begin
         diag_code = DIAG_UNDERV;
      end else if (supply_over) begin
         diag_code = DIAG_OVERV;
      end else if (temp_high) begin
         diag_code = DIAG_TEMP;
      end else if (mem_sbe) begin
         diag_code = DIAG_SBE;
      end else begin
         diag_code = DIAG_OK;
      end
   end
endmodule
`default_nettype wire

/* logic/ssc_scheduler.sv */
// Purpose: slow channel message scheduler and serialiser with apb registers
// Assumes: frame_tick pulses once per sent frame, synchronous to pclk
// Notes:   drives status nibble bits 3..1; the fast channel is elsewhere
//
// Function
// - slow channel uses status bits 2, 3
// - one message spans 18 consecutive frames
// - enhanced format: 8-bit id, 12-bit data
// - fixed cycle ids 01,23,1c,03,29,05,06,01,23,1c
// - positions 11-18 send user codes 90h-97h
// - diag 000 normal, 001 high, 002 low
// - diag 020-023 voltage, temperature, memory error
// - warnings set status bit 1 when enabled
// - safety codes 801-fff, 024-800 never sent
// - safety bit 11 mirrors diagnostic-mode flag
// - safety bits 10..6 flag listed checks
// - safety bits 5..0 flag listed checks
// - type settings 0-7 map to 051-05a
// - type settings 8-b map 062-066, rest 000
// - cycle runs only when serial enable set
// - temperature message carries 8-bit value
// - supply message carries 9-bit value
// - mask bit forces pre-warning bit low
`timescale 1ns/100ps
`default_nettype none
module ssc_scheduler
   import ssc_pkg::*;
#(
   parameter logic [11:0] MFR_CODE = 12'h0a5    // arbitrary value
)(
   input  wire logic        pclk,                // bus and block clock
   input  wire logic        presetn,             // async reset, active low
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_tick,          // one pulse per frame start
   input  wire logic        upper_range_limit,
   input  wire logic        lower_range_limit,
   input  wire logic        supply_under,
   input  wire logic        supply_over,
   input  wire logic        temp_high,
   input  wire logic        mem_sbe,
   input  wire logic [10:0] check_fail,
   input  wire logic [7:0]  temperature,         // 8-bit temperature sample
   input  wire logic [8:0]  supply_level,        // 9-bit supply sample
   output logic             status_bit3,         // serial message bit 3
   output logic             status_bit2,         // serial data bit 2
   output logic             status_bit1          // pre-warning bit
);
   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   logic [7:0]  cfg1;                 // sent_config_word_one
   logic [1:0]  cfg2;                 // sent_config_word_two
   logic        diag_flag;            // control_word_one diagnostic mode
   logic [11:0] oem [N_OEM];          // user code words
   logic [4:0]  msg_idx;              // message position 0..17
   logic [4:0]  frame_idx;            // frame position 0..17
   logic [17:0] sh3;                  // bit 3 pattern, bit 16 goes next
   logic [17:0] sh2;                  // bit 2 pattern, bit 16 goes next
   logic [11:0] data_q;               // data value held for the slot

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   wire logic        acc_ph  = psel & penable;                // access phase
   wire logic        wr_go   = acc_ph & pwrite & pready;      // completing write
   wire logic        hit_c1  = (paddr == OFS_CFG1);
   wire logic        hit_c2  = (paddr == OFS_CFG2);
   wire logic        hit_ct  = (paddr == OFS_CONTROL_WORD_ONE);
   wire logic        hit_st  = (paddr == OFS_STAT);
   wire logic        hit_oem = (paddr >= OFS_OEM0) && (paddr < OFS_OEM0 + 12'h020) && (paddr[1:0] == 2'b00);
   wire logic [2:0]  oem_sel = 3'((paddr - OFS_OEM0) >> 2);
   wire logic        mapped  = hit_c1 | hit_c2 | hit_ct | hit_st | hit_oem;
   wire logic        ese     = cfg1[CFG1_ESE_BIT];
   wire logic        pw_en   = cfg2[CFG2_PWEN_BIT];
   wire logic        pw_mask = cfg2[CFG2_PWMASK_BIT];
   wire logic [31:0] next_prdata;

   // read mux; unmapped reads return zero with an error
   assign next_prdata = hit_c1  ? {24'h000000, cfg1} :
                        hit_c2  ? {30'h00000000, cfg2} :
                        hit_ct  ? (32'(diag_flag) << CONTROL_WORD_ONE_DIAG_BIT) :
                        hit_st  ? {21'h000000, ese, 5'(msg_idx), 5'(frame_idx)} :
                        hit_oem ? {20'h00000, oem[oem_sel]} : 32'h00000000;

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= acc_ph & ~pready;
         pslverr <= acc_ph & ~pready & ~mapped;
         prdata  <= (acc_ph & ~pready & ~pwrite) ? next_prdata : 32'h00000000;
      end
   end

   // control words, written only on the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg1      <= CFG1_RST;
         cfg2      <= CFG2_RST;
         diag_flag <= CONTROL_WORD_ONE_RST;
      end else if (wr_go) begin
         if (hit_c1) begin
            cfg1 <= pwdata[7:0];
         end else if (hit_c2) begin
            cfg2 <= pwdata[1:0];
         end else if (hit_ct) begin
            diag_flag <= pwdata[CONTROL_WORD_ONE_DIAG_BIT];
         end
      end
   end

   // user code words, one per entry
   for (genvar g = 0; g < N_OEM; g++) begin : g_oem
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            oem[g] <= OEM_RST;
         end else if (wr_go && hit_oem && (oem_sel == 3'(g))) begin
            oem[g] <= pwdata[11:0];
         end
      end
   end

   // ------------------------------------------------------------
   // message content
   // ------------------------------------------------------------
   logic [11:0] diag_code;
   logic [11:0] type_code;
   logic        any_warn;
   logic [5:0]  crc;
   logic [23:0] crc_in;

   ssc_diag_enc u_enc (
      .upper_range_limit (upper_range_limit),
      .lower_range_limit (lower_range_limit),
      .supply_under      (supply_under),
      .supply_over       (supply_over),
      .temp_high         (temp_high),
      .mem_sbe           (mem_sbe),
      .diag_mode         (diag_flag),
      .check_fail        (check_fail),
      .sensor_type       (cfg1[CFG1_TYPE_LSB +: 4]),
      .diag_code         (diag_code),
      .type_code         (type_code),
      .any_warn          (any_warn)
   );

   // reserved band 024h..800h must never reach the slot
   diag_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      (diag_code < DIAG_RSV_LO) || (diag_code >= DIAG_SAFE_MIN))
      else $error("diagnostic code in reserved band");
   // a safety code implies the diagnostic-mode flag
   safe_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      diag_code >= DIAG_SAFE_MIN |-> diag_flag)
      else $error("safety code without diagnostic mode");

   wire logic [7:0]  cur_id = MSG_ID[msg_idx];
   wire logic [11:0] cur_data =
      (cur_id == ID_DIAG) ? diag_code :
      (cur_id == ID_TEMP) ? {4'h0, temperature} :
      (cur_id == ID_VSUP) ? {3'h0, supply_level} :
      (cur_id == ID_TYPE) ? type_code :
      (cur_id == ID_SID)  ? (cfg1[CFG1_SID_BIT] ? SID_CODE1 : SID_CODE0) :
      (cur_id == ID_MFR)  ? MFR_CODE :
      (cur_id == ID_REV)  ? REV_CODE[cfg1[CFG1_REV_LSB +: 2]] :
      (cur_id[7:4] == ID_OEM_HI) ? oem[cur_id[2:0]] : 12'h000;

   // frame layout: bit 3 carries start, config, id; bit 2 crc then data
   wire logic [17:0] pat3 = {START_PAT, CFG_BIT, cur_id[7:4], 1'b0, cur_id[3:0], 1'b0};
   wire logic [17:0] pat2 = {crc, cur_data};

   // crc covers frames 7..18, bit 3 before bit 2 in each frame
   for (genvar j = 0; j < 12; j++) begin : g_crc
      assign crc_in[2*j+1] = pat3[j];
      assign crc_in[2*j]   = cur_data[j];
   end

   ssc_crc6 u_crc (
      .crc_data (crc_in),
      .crc_out  (crc)
   );

   // ------------------------------------------------------------
   // frame and message sequencing
   // ------------------------------------------------------------
   wire logic       last_frame = (frame_idx == 5'(N_FRAMES - 1));
   wire logic       last_msg   = (msg_idx == 5'(N_MSG - 1));
   wire logic [4:0] next_frame = last_frame ? 5'd0 : frame_idx + 5'd1;
   wire logic [4:0] next_msg   = last_msg ? 5'd0 : msg_idx + 5'd1;
   wire logic       slot_start = frame_tick & ese & (frame_idx == 5'd0);

   // positions restart at message 1 whenever the channel is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_idx <= 5'd0;
         msg_idx   <= 5'd0;
      end else if (!ese) begin
         frame_idx <= 5'd0;
         msg_idx   <= 5'd0;
      end else if (frame_tick) begin
         frame_idx <= next_frame;
         msg_idx   <= last_frame ? next_msg : msg_idx;
      end
   end

   // load a whole message at slot start so content cannot tear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh3    <= 18'h00000;
         sh2    <= 18'h00000;
         data_q <= 12'h000;
      end else if (!ese) begin
         sh3 <= 18'h00000;
         sh2 <= 18'h00000;
      end else if (slot_start) begin
         sh3    <= pat3;
         sh2    <= pat2;
         data_q <= cur_data;
      end else if (frame_tick) begin
         sh3 <= {sh3[16:0], 1'b0};
         sh2 <= {sh2[16:0], 1'b0};
      end
   end

   // status outputs change only at frame start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_bit3 <= 1'b0;
         status_bit2 <= 1'b0;
         status_bit1 <= 1'b0;
      end else if (frame_tick) begin
         status_bit3 <= ese & (slot_start ? pat3[17] : sh3[16]);
         status_bit2 <= ese & (slot_start ? pat2[17] : sh2[16]);
         status_bit1 <= pw_en & ~pw_mask & any_warn;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   frame_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      ese && frame_tick && last_frame |=> frame_idx == 5'd0)
      else $error("frame index did not wrap after 18 frames");
   msg_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      ese && frame_tick && last_frame && last_msg |=> msg_idx == 5'd0)
      else $error("message index did not wrap after 18 messages");
   msg_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      ese && frame_tick && !last_frame |=> $stable(msg_idx))
      else $error("message changed inside its slot");
   start_pat_a: assert property (@(posedge pclk) disable iff (!presetn)
      ese && slot_start |=> status_bit3 && sh3[16:11] == 6'b111110)
      else $error("start pattern missing on bit 3");
   hold_data_a: assert property (@(posedge pclk) disable iff (!presetn)
      ese && !slot_start && $past(ese) |=> $stable(data_q))
      else $error("slot data changed mid message");
   off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ese && frame_tick |=> !status_bit3 && !status_bit2)
      else $error("serial bits active while disabled");
   warn_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      pw_mask && frame_tick |=> !status_bit1)
      else $error("pre-warning bit set while masked");
   warn_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      pw_en && !pw_mask && any_warn && frame_tick |=> status_bit1)
      else $error("pre-warning bit not raised");
   apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("pready not a single wait state pulse");

   // ------------------------------------------------------------
   // content and parking checks
   // ------------------------------------------------------------
   // disabled channel waits at message 1, frame 1
   idle_park_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ese |=> msg_idx == 5'd0 && frame_idx == 5'd0)
      else $error("schedule not parked while disabled");
   // status bits only move on a frame tick
   stat_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !frame_tick |=> $stable(status_bit3) && $stable(status_bit2) && $stable(status_bit1))
      else $error("status bits changed between frames");
   // user code slots in ascending id order
   oem_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      msg_idx >= 5'd10 |-> cur_id[7:4] == ID_OEM_HI && cur_id[2:0] == 3'(msg_idx - 5'd10))
      else $error("user code slot out of order");
   // upper data bits stay clear for 8-bit and 9-bit values
   temp_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      slot_start && cur_id == ID_TEMP |=> data_q[11:8] == 4'h0)
      else $error("temperature data wider than 8 bits");
   vsup_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      slot_start && cur_id == ID_VSUP |=> data_q[11:9] == 3'h0)
      else $error("supply data wider than 9 bits");
endmodule
`default_nettype wire

/* dv/ssc_sent_rx.sv */
// Purpose: slow channel receiver model beside the status bits
// Assumes: each frame's bits are read at the next frame tick
// Notes:   flags one well-framed 18-frame message at a time
`timescale 1ns/100ps
`default_nettype none
module ssc_sent_rx
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        frame_tick,
   input  wire logic        bit3,
   input  wire logic        bit2,
   output logic             msg_stb,    // one cycle per message
   output logic      [7:0]  msg_id,
   output logic      [11:0] msg_data,
   output logic             crc_ok
);
   logic [17:0] s3, s2, n3;             // frame history, newest in bit 0
   logic [5:0]  c;                      // running crc
   assign n3 = {s3[16:0], bit3};
   // ----------------------------------
   // history and start pattern search
   // ----------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {s3, s2, msg_stb} <= '0;
      end else begin
         // a message only counts once all 18 frames are in
         msg_stb <= frame_tick && n3[17:11] == 7'h7e && n3[10] && !n3[5] && !n3[0];
         if (frame_tick) begin
            s3 <= n3;
            s2 <= {s2[16:0], bit2};
         end
      end
   end
   assign msg_id   = {s3[9:6], s3[4:1]};
   assign msg_data = s2[11:0];
   // crc over frames 7..18, bit 3 before bit 2
   always_comb begin
      c = 6'h15;
      for (int i = 23; i >= 0; i--) begin
         c = {c[4:0], 1'b0} ^ ((c[5] ^ (i[0] ? s3[i / 2] : s2[i / 2])) ? 6'h19 : 6'h00);
      end
      crc_ok = (c === s2[17:12]);
   end
endmodule
`default_nettype wire

/* dv/sent_slow_channel_scheduler_bench.sv */
// Purpose: self-checking bench for the slow channel scheduler
// Assumes: a frame tick every third pclk
// Notes:   diagnostic rows in a table, schedule and types in loops
`timescale 1ns/100ps
`default_nettype none
module sent_slow_channel_scheduler_bench;
   import ssc_pkg::*;
   typedef struct packed {logic [1:0] c2; logic dg; logic [5:0] cd; logic [10:0] cf; logic [11:0] code; logic pw;} ssc_row_s;
   localparam logic [11:0] MFR = 12'h3c6; // arbitrary value
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_tick, b3, b2, b1, stb, ok, err;
   logic [5:0]  cond;                  // upper, lower, under, over, temp, sbe
   logic [10:0] check_fail;
   logic [11:0] paddr, dat, gdat;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  id, gid, temperature;
   logic [8:0]  supply_level;
   int          mismatches = 0, total_checks = 0, k = 0;
   logic [11:0] types [16] = '{12'h051, 12'h052, 12'h053, 12'h054, 12'h055, 12'h056, 12'h059, 12'h05a,
                               12'h062, 12'h063, 12'h064, 12'h066, 12'h000, 12'h000, 12'h000, 12'h000};
   logic [7:0]  ids [10] = '{8'h01, 8'h23, 8'h1c, 8'h03, 8'h29, 8'h05, 8'h06, 8'h01, 8'h23, 8'h1c};
   logic [11:0] eds [10] = '{12'h000, 12'h0a7, 12'h1c3, 12'h059, 12'hfff, MFR, 12'h003, 12'h000, 12'h0a7, 12'h1c3};
   // cfg2, diag flag, conditions, failed checks, code, pre-warning
   ssc_row_s    rows [12] = '{
      '{2'h2, 1'h0, 6'h00, 11'h155, 12'h000, 1'h0}, '{2'h2, 1'h0, 6'h20, 11'h000, 12'h001, 1'h1},
      '{2'h2, 1'h0, 6'h10, 11'h000, 12'h002, 1'h1}, '{2'h2, 1'h0, 6'h08, 11'h000, 12'h020, 1'h1},
      '{2'h2, 1'h0, 6'h04, 11'h000, 12'h021, 1'h1}, '{2'h2, 1'h0, 6'h02, 11'h000, 12'h022, 1'h1},
      '{2'h2, 1'h0, 6'h01, 11'h000, 12'h023, 1'h1}, '{2'h3, 1'h0, 6'h20, 11'h000, 12'h001, 1'h0},
      '{2'h0, 1'h0, 6'h01, 11'h000, 12'h023, 1'h0}, '{2'h2, 1'h1, 6'h00, 11'h001, 12'h801, 1'h0},
      '{2'h2, 1'h1, 6'h20, 11'h400, 12'hc00, 1'h1}, '{2'h2, 1'h1, 6'h00, 11'h7ff, 12'hfff, 1'h0}};
   ssc_scheduler #(.MFR_CODE(MFR)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .frame_tick, .upper_range_limit(cond[5]), .lower_range_limit(cond[4]),
      .supply_under(cond[3]), .supply_over(cond[2]), .temp_high(cond[1]), .mem_sbe(cond[0]), .check_fail,
      .temperature, .supply_level, .status_bit3(b3), .status_bit2(b2), .status_bit1(b1));
   ssc_sent_rx rx (.pclk, .presetn, .frame_tick, .bit3(b3), .bit2(b2), .msg_stb(stb), .msg_id(id),
      .msg_data(dat), .crc_ok(ok));
   // ----------------------------------
   // clock, frame ticks and helpers
   // ----------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      k <= (k == 2) ? 0 : k + 1;
      frame_tick <= (k == 2);
   end
   task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic abort;
      mismatches++;
      tally_and_finish();
   endtask
   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 9);
      if (n == 9) abort();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic msg;
      int n = 0;
      do @(posedge pclk); while (stb !== 1'b1 && ++n < 99);
      if (n == 99) abort();
      gid = id;
      gdat = dat;
      check("crc", 12'h001, {11'h0, ok});
   endtask
   // first message is dropped: it may predate the latest input change
   task automatic find(input logic [7:0] want);
      int n = 0;
      msg();
      do msg(); while (gid !== want && ++n < 19);
      if (gid !== want) abort();
   endtask
   // ----------------------------------
   // main sequence
   // ----------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, frame_tick, cond, check_fail, presetn} = '0;
      temperature = 8'ha7;
      supply_level = 9'h1c3;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_STAT, 0);
      check("status", 12'h000, {rd[10:0], b3 | b2 | b1});
      for (int i = 0; i < 8; i++) apb(1, OFS_OEM0 + 12'(4 * i), 32'(241 * (i + 1)));
      apb(1, OFS_CFG2, 2);
      apb(1, OFS_CFG1, 32'h6d);
      msg();
      for (int m = 0; m < 19; m++) begin
         if (m > 0) msg();
         check("id", {4'h0, m < 10 ? ids[m] : m < 18 ? 8'(m + 134) : 8'h01}, {4'h0, gid});
         if (m < 18) check("data", m < 10 ? eds[m] : 12'(241 * (m - 9)), gdat);
      end
      apb(0, 12'hffc, 0);
      check("slverr", 12'h001, {11'h0, err});
      apb(1, OFS_CFG1, 32'h6c);
      repeat (60) @(posedge pclk);
      apb(0, OFS_STAT, 0);
      check("idle", 12'h000, {rd[10:0], b3 | b2});
      apb(1, OFS_CFG1, 32'h6d);
      msg();
      check("first", 12'h001, {4'h0, gid});
      foreach (rows[r]) begin
         apb(1, OFS_CFG2, {30'h0, rows[r].c2});
         apb(1, OFS_CONTROL_WORD_ONE, {17'h0, rows[r].dg, 14'h0});
         cond <= rows[r].cd;
         check_fail <= rows[r].cf;
         find(8'h01);
         check("diag", rows[r].code, gdat);
         check("prewarn", {11'h0, rows[r].pw}, {11'h0, b1});
      end
      for (int t = 0; t < 16; t++) begin
         apb(1, OFS_CFG1, {24'h0, 4'(t), 2'b11, t[3], 1'b1});
         find(8'h03);
         check("type", types[t], gdat);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
